// >>> lcdpd_top.sv
`include "lcdpd_cfg.svh"
module lcdpd_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fast_osc_ck,
	input wire logic sub_osc_ck,
	output lcdpd_pkg::lcdpd_pins_t panel,
	output lcdpd_pkg::lcdpd_analog_t analog,
	output logic panel_power_on,
	output logic sub_osc_enable
);
	import lcdpd_pkg::*;
	typedef enum logic [1:0] {
		LCDPD_W_IDLE = 2'b01,
		LCDPD_W_RESP = 2'b10
	} lcdpd_wst_t;
	typedef struct packed {
		lcdpd_wst_t wst;
		logic aw_got;
		logic w_got;
		lcdpd_wr_t wr;
		logic bvalid;
		logic [1:0] bresp;
		logic rpend;
		logic [11:0] raddr;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] frame_cfg;
		logic [7:0] osc_cfg;
		logic [7:0] strong_cfg;
		logic [7:0] panel_cfg;
		logic [7:0] scan_out;
		logic [3:0] gpo;
		logic [2:0] phase;
		logic mwen;
		logic [5:0] mwaddr;
		logic [7:0] mwdata;
		lcdpd_pins_t pins;
		lcdpd_analog_t ana;
		logic pwr_on;
		logic awrdy;
		logic wrdy;
		logic arrdy;
	} lcdpd_st_t;
	lcdpd_st_t st_ff, nxt_st;
	logic tick;
	logic [7:0] mem_rd;
	logic [319:0] flat;
	logic [39:0] seg_v;
	logic [7:0] com_v;
	logic in_mem;
	logic [11:0] mofs;
	logic [11:0] widx;
	logic [11:0] ridx;
	logic eighth;
	logic [2:0] last_phase;
	lcdpd_tick u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.fast_osc_ck(fast_osc_ck),
		.sub_osc_ck(sub_osc_ck),
		.sub_enable(st_ff.osc_cfg[`LCDPD_SUB_EN_BIT]),
		.sel(st_ff.frame_cfg[`LCDPD_SEL_TOP:0]),
		.tick(tick)
	);
	lcdpd_mem u_mem (
		.aclk(aclk),
		.wen(st_ff.mwen),
		.waddr(st_ff.mwaddr),
		.wdata(st_ff.mwdata),
		.raddr(mofs[5:0]),
		.rdata(mem_rd),
		.flat(flat)
	);
	// byte address to register index, one word per register
	assign widx = {2'b00, st_ff.wr.addr[11:2]};
	assign ridx = {2'b00, st_ff.raddr[11:2]};
	assign mofs = ridx - `LCDPD_OFS_MEM;
	assign s_axi_awready = st_ff.awrdy;
	assign s_axi_wready = st_ff.wrdy;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.arrdy;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign panel = st_ff.pins;
	assign analog = st_ff.ana;
	assign panel_power_on = st_ff.pwr_on;
	assign sub_osc_enable = st_ff.osc_cfg[`LCDPD_SUB_EN_BIT];
	assign eighth = st_ff.panel_cfg[`LCDPD_DUTY_BIT];
	assign last_phase = eighth ? 3'h7 : 3'h3;
	genvar g;
	generate
		for (g = 0; g < 40; g++) begin : g_seg
			assign seg_v[g] = flat[g*8 + 32'(st_ff.phase)];
		end
		for (g = 0; g < 8; g++) begin : g_com
			assign com_v[g] = (st_ff.phase == 3'(g));
		end
	endgenerate
	always_comb begin
		nxt_st = st_ff;
		nxt_st.mwen = 1'b0;
		in_mem = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.wr.addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wr.data = s_axi_wdata;
			nxt_st.wr.strb = s_axi_wstrb;
		end
		case (st_ff.wst)
			LCDPD_W_IDLE: begin
				if (st_ff.aw_got && st_ff.w_got) begin
					nxt_st.wst = LCDPD_W_RESP;
					nxt_st.bvalid = 1'b1;
					nxt_st.bresp = 2'b00;
					if (st_ff.wr.strb[0]) begin
						case (widx)
							`LCDPD_OFS_FRAME:
								nxt_st.frame_cfg = st_ff.wr.data[7:0] & `LCDPD_FRAME_MASK;
							`LCDPD_OFS_OSC:
								nxt_st.osc_cfg = st_ff.wr.data[7:0] & `LCDPD_OSC_MASK;
							`LCDPD_OFS_STRONG:
								nxt_st.strong_cfg = st_ff.wr.data[7:0] & `LCDPD_STRONG_MASK;
							`LCDPD_OFS_PANEL:
								nxt_st.panel_cfg = st_ff.wr.data[7:0];
							`LCDPD_OFS_SCAN:
								nxt_st.scan_out = st_ff.wr.data[7:0];
							`LCDPD_OFS_GPO:
								nxt_st.gpo = st_ff.wr.data[3:0];
							default: begin
								in_mem = (widx >= `LCDPD_OFS_MEM) &&
									(widx < `LCDPD_OFS_MEM + 12'(`LCDPD_MEM_WORDS));
								if (in_mem) begin
									nxt_st.mwen = 1'b1;
									nxt_st.mwaddr = 6'(widx - `LCDPD_OFS_MEM);
									nxt_st.mwdata = st_ff.wr.data[7:0];
								end else begin
									nxt_st.bresp = 2'b10;
								end
							end
						endcase
					end
				end
			end
			LCDPD_W_RESP: begin
				if (s_axi_bready) begin
					nxt_st.bvalid = 1'b0;
					nxt_st.aw_got = 1'b0;
					nxt_st.w_got = 1'b0;
					nxt_st.wst = LCDPD_W_IDLE;
				end
			end
			default: nxt_st.wst = LCDPD_W_IDLE;
		endcase
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_st.rpend = 1'b1;
			nxt_st.raddr = s_axi_araddr;
		end
		if (st_ff.rpend) begin
			nxt_st.rpend = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = 2'b00;
			nxt_st.rdata = '0;
			case (ridx)
				`LCDPD_OFS_FRAME: nxt_st.rdata[7:0] = st_ff.frame_cfg;
				`LCDPD_OFS_OSC: nxt_st.rdata[7:0] = st_ff.osc_cfg;
				`LCDPD_OFS_STRONG: nxt_st.rdata[7:0] = st_ff.strong_cfg;
				`LCDPD_OFS_PANEL: nxt_st.rdata = '0; // write only
				`LCDPD_OFS_SCAN: nxt_st.rdata[7:0] = st_ff.scan_out;
				`LCDPD_OFS_GPO: nxt_st.rdata[3:0] = st_ff.gpo;
				default: begin
					if (ridx >= `LCDPD_OFS_MEM &&
						ridx < `LCDPD_OFS_MEM + 12'(`LCDPD_MEM_WORDS))
						nxt_st.rdata[7:0] = mem_rd;
					else
						nxt_st.rresp = 2'b10;
				end
			endcase
		end
		if (st_ff.rvalid && s_axi_rready)
			nxt_st.rvalid = 1'b0;
		// commons keep scanning even when blanked
		if (tick) begin
			nxt_st.phase = (st_ff.phase >= last_phase) ? 3'h0 : st_ff.phase + 3'h1;
		end
		nxt_st.pwr_on = !st_ff.panel_cfg[`LCDPD_PWR_BIT];
		nxt_st.pins.com = com_v & (eighth ? 8'hFF : 8'h0F);
		nxt_st.pins.seg = st_ff.panel_cfg[`LCDPD_BLANK_BIT] ? 40'h0 : seg_v;
		if (eighth && st_ff.panel_cfg[`LCDPD_COMMON_PIN_REUSE_BIT])
			nxt_st.pins.com[7:4] = st_ff.scan_out[7:4];
		if (st_ff.panel_cfg[`LCDPD_SEGMENT_PIN_REUSE_BIT])
			nxt_st.pins.seg[3:0] = st_ff.gpo;
		if (st_ff.panel_cfg[`LCDPD_PWR_BIT]) begin
			nxt_st.pins.seg[39:4] = '0;
			nxt_st.pins.com = '0;
			if (!st_ff.panel_cfg[`LCDPD_SEGMENT_PIN_REUSE_BIT])
				nxt_st.pins.seg[3:0] = '0;
		end
		nxt_st.ana.level = {st_ff.strong_cfg[`LCDPD_HEAVY_BIT],
			st_ff.panel_cfg[`LCDPD_ENHANCED_LOAD_DRIVE_BIT], st_ff.frame_cfg[`LCDPD_DRV_LO +: 3]};
		nxt_st.ana.contrast = 3'h4 - {1'b0, st_ff.panel_cfg[`LCDPD_CTR_LO +: 2]};
		nxt_st.ana.eighth_duty = eighth;
		nxt_st.awrdy = (nxt_st.wst == LCDPD_W_IDLE) && !nxt_st.aw_got;
		nxt_st.wrdy = (nxt_st.wst == LCDPD_W_IDLE) && !nxt_st.w_got;
		nxt_st.arrdy = !nxt_st.rpend && !nxt_st.rvalid;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.wst <= LCDPD_W_IDLE;
			st_ff.frame_cfg <= `LCDPD_RST_FRAME;
			st_ff.osc_cfg <= `LCDPD_RST_OSC;
			st_ff.strong_cfg <= `LCDPD_RST_STRONG;
			st_ff.panel_cfg <= `LCDPD_RST_PANEL;
			st_ff.ana.contrast <= 3'h4;
			st_ff.awrdy <= 1'b1;
			st_ff.wrdy <= 1'b1;
			st_ff.arrdy <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end
	property p_phase_wrap;
		@(posedge aclk) disable iff (!aresetn)
		(tick && st_ff.phase >= last_phase) |=> st_ff.phase == 3'h0;
	endproperty
	a_phase_wrap: assert property (p_phase_wrap) else $error("scan phase did not wrap");
	property p_quarter_com;
		@(posedge aclk) disable iff (!aresetn)
		(!eighth && $stable(st_ff.panel_cfg)) |=> panel.com[7:4] == 4'h0;
	endproperty
	a_quarter_com: assert property (p_quarter_com) else $error("upper commons in quarter duty");
	property p_one_com;
		@(posedge aclk) disable iff (!aresetn)
		(!st_ff.panel_cfg[`LCDPD_COMMON_PIN_REUSE_BIT] && $stable(st_ff.panel_cfg)) |=> $onehot0(panel.com);
	endproperty
	a_one_com: assert property (p_one_com) else $error("more than one common active");
	property p_blank;
		@(posedge aclk) disable iff (!aresetn)
		(st_ff.panel_cfg[`LCDPD_BLANK_BIT] && !st_ff.panel_cfg[`LCDPD_SEGMENT_PIN_REUSE_BIT]) |=> panel.seg == 40'h0;
	endproperty
	a_blank: assert property (p_blank) else $error("segments driven while blanked");
	property p_power;
		@(posedge aclk) disable iff (!aresetn)
		st_ff.panel_cfg[`LCDPD_PWR_BIT] |=> !panel_power_on && panel.com == 8'h00;
	endproperty
	a_power: assert property (p_power) else $error("panel powered while off requested");
	property p_level;
		@(posedge aclk) disable iff (!aresetn)
		$stable(st_ff.strong_cfg) && $stable(st_ff.frame_cfg) |=>
			analog.level[2:0] == $past(st_ff.frame_cfg[5:3]) && analog.level[4] == $past(st_ff.strong_cfg[1]);
	endproperty
	a_level: assert property (p_level) else $error("drive level mismatch");
	property p_contrast;
		@(posedge aclk) disable iff (!aresetn)
		st_ff.panel_cfg[2:1] == 2'b11 |=> analog.contrast == 3'h1;
	endproperty
	a_contrast: assert property (p_contrast) else $error("contrast minimum wrong");
	property p_seg_reuse;
		@(posedge aclk) disable iff (!aresetn)
		st_ff.panel_cfg[`LCDPD_SEGMENT_PIN_REUSE_BIT] |=> panel.seg[3:0] == $past(st_ff.gpo);
	endproperty
	a_seg_reuse: assert property (p_seg_reuse) else $error("segment reuse pins wrong");
	property p_com_reuse;
		@(posedge aclk) disable iff (!aresetn)
		(eighth && st_ff.panel_cfg[`LCDPD_COMMON_PIN_REUSE_BIT] && !st_ff.panel_cfg[7]) |=>
			panel.com[7:4] == $past(st_ff.scan_out[7:4]);
	endproperty
	a_com_reuse: assert property (p_com_reuse) else $error("common reuse pins wrong");
	property p_rd_answer;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_arvalid && s_axi_arready) |-> ##2 s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_mem_write;
		@(posedge aclk) disable iff (!aresetn)
		st_ff.mwen |=> flat[32'($past(st_ff.mwaddr)) * 8 +: 8] == $past(st_ff.mwdata);
	endproperty
	a_mem_write: assert property (p_mem_write) else $error("display memory write lost");
	c_mem_write: cover property (@(posedge aclk) disable iff (!aresetn) st_ff.mwen);
	c_wrap8: cover property (@(posedge aclk) disable iff (!aresetn) eighth && tick && st_ff.phase == 3'h7);
	c_blank: cover property (@(posedge aclk) disable iff (!aresetn) st_ff.panel_cfg[6] && tick);
endmodule // lcdpd_top

// >>> lcdpd_cfg.svh
`ifndef LCDPD_CFG_SVH
`define LCDPD_CFG_SVH
// How it works
// - quarter duty 160 dots, eighth duty 320
// - forty segments from display memory, eight commons from the scan phase
// - reset leaves display memory contents untouched
// - select codes 0-3 divide fast oscillator
// - select top bit uses crystal over 512
// - drive level: heavy, enhanced, three drive bits
// - control bit 7 set powers panel off
// - bit 6 blanks segments, commons keep scanning
// - eighth duty reuse frees commons 7 to 4
// - one byte per segment, bit k common k
// - display memory readable and writable while scanned
`define LCDPD_OFS_FRAME 12'h020
`define LCDPD_OFS_OSC 12'h023
`define LCDPD_OFS_STRONG 12'h038
`define LCDPD_OFS_PANEL 12'h03A
`define LCDPD_OFS_SCAN 12'h00F
`define LCDPD_OFS_GPO 12'h010
`define LCDPD_OFS_MEM 12'h200
`define LCDPD_MEM_WORDS 40
`define LCDPD_RST_FRAME 8'h04
`define LCDPD_RST_OSC 8'h00
`define LCDPD_RST_STRONG 8'h00
`define LCDPD_RST_PANEL 8'h00
`define LCDPD_FRAME_MASK 8'h3F
`define LCDPD_OSC_MASK 8'hE0
`define LCDPD_STRONG_MASK 8'h02
`define LCDPD_SEL_TOP 2
`define LCDPD_DRV_LO 3
`define LCDPD_HEAVY_BIT 1
`define LCDPD_SUB_EN_BIT 6
`define LCDPD_PWR_BIT 7
`define LCDPD_BLANK_BIT 6
`define LCDPD_COMMON_PIN_REUSE_BIT 5
`define LCDPD_ENHANCED_LOAD_DRIVE_BIT 4
`define LCDPD_SEGMENT_PIN_REUSE_BIT 3
`define LCDPD_CTR_LO 1
`define LCDPD_DUTY_BIT 0
`define LCDPD_DIV_FAST_LOG2 14
`define LCDPD_DIV_SUB_LOG2 9
`endif

// >>> lcdpd_pkg.sv
package lcdpd_pkg;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} lcdpd_wr_t;
	typedef struct packed {
		logic [39:0] seg;
		logic [7:0] com;
	} lcdpd_pins_t;
	typedef struct packed {
		logic [4:0] level;
		logic [2:0] contrast;
		logic eighth_duty;
	} lcdpd_analog_t;
endpackage

// >>> lcdpd_tick.sv
`include "lcdpd_cfg.svh"
module lcdpd_tick (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic fast_osc_ck,
	input wire logic sub_osc_ck,
	input wire logic sub_enable,
	input wire logic [2:0] sel,
	output logic tick
);
	import lcdpd_pkg::*;
	typedef struct packed {
		logic [2:0] fs;
		logic [2:0] ss;
		logic [16:0] fcnt;
		logic [8:0] scnt;
		logic tick;
	} lcdpd_tick_st_t;
	lcdpd_tick_st_t st_ff, nxt_st;
	logic frise, srise;
	logic [16:0] flim;
	assign tick = st_ff.tick;
	always_comb begin
		nxt_st = st_ff;
		nxt_st.fs = {st_ff.fs[1:0], fast_osc_ck};
		nxt_st.ss = {st_ff.ss[1:0], sub_osc_ck};
		frise = st_ff.fs[1] & ~st_ff.fs[2];
		srise = st_ff.ss[1] & ~st_ff.ss[2];
		flim = 17'((32'h1 << (`LCDPD_DIV_FAST_LOG2 + 3 - 32'(sel[1:0]))) - 32'h1);
		nxt_st.tick = 1'b0;
		if (frise) begin
			if (st_ff.fcnt >= flim) begin
				nxt_st.fcnt = '0;
				if (!sel[`LCDPD_SEL_TOP])
					nxt_st.tick = 1'b1;
			end else begin
				nxt_st.fcnt = st_ff.fcnt + 17'h00001;
			end
		end
		if (srise && sub_enable) begin
			nxt_st.scnt = st_ff.scnt + 9'h001;
			if (st_ff.scnt == 9'h1FF && sel[`LCDPD_SEL_TOP])
				nxt_st.tick = 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	property p_tick_pulse;
		@(posedge aclk) disable iff (!aresetn)
		tick |=> !tick;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("frame tick longer than one cycle");
	property p_sub_wrap;
		@(posedge aclk) disable iff (!aresetn)
		(tick && $past(sel[`LCDPD_SEL_TOP])) |-> st_ff.scnt == 9'h000;
	endproperty
	a_sub_wrap: assert property (p_sub_wrap) else $error("crystal tick off its count");
endmodule // lcdpd_tick

// >>> lcdpd_mem.sv
`include "lcdpd_cfg.svh"
module lcdpd_mem (
	input wire logic aclk,
	input wire logic wen,
	input wire logic [5:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [5:0] raddr,
	output logic [7:0] rdata,
	output logic [319:0] flat
);
	import lcdpd_pkg::*;
	logic [7:0] mem [0:`LCDPD_MEM_WORDS-1];
	// no reset: contents random after power on
	always_ff @(posedge aclk) begin
		if (wen)
			mem[waddr] <= wdata;
	end
	assign rdata = mem[raddr];
	genvar g;
	generate
		for (g = 0; g < `LCDPD_MEM_WORDS; g++) begin : g_flat
			assign flat[g*8 +: 8] = mem[g];
		end
	endgenerate
endmodule // lcdpd_mem

// >>> lcdpd_glass.sv
module lcdpd_glass (
	input wire logic aclk,
	input wire logic clr,
	input wire lcdpd_pkg::lcdpd_pins_t panel,
	output logic [319:0] image,
	output logic [7:0] com_seen,
	output int multi
);
	timeunit 1ns;
	timeprecision 100ps;
	import lcdpd_pkg::*;
	// glass remembers the last level each dot saw while its common was driven
	always @(posedge aclk) begin
		if (clr) begin
			com_seen <= 8'h00;
			multi <= 0;
		end else begin
			com_seen <= com_seen | panel.com;
			if (!$onehot0(panel.com)) multi <= multi + 1;
		end
		for (int k = 0; k < 8; k++) begin
			if (panel.com[k]) begin
				for (int g = 0; g < 40; g++) image[g * 8 + k] <= panel.seg[g];
			end
		end
	end
endmodule // lcdpd_glass

// >>> lcd_panel_driver_tb_top.sv
module lcd_panel_driver_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import lcdpd_pkg::*;
	localparam logic [11:0] a_frame = 12'h020 * 4;
	localparam logic [11:0] a_osc = 12'h023 * 4;
	localparam logic [11:0] a_strong = 12'h038 * 4;
	localparam logic [11:0] a_panel = 12'h03A * 4;
	localparam logic [11:0] a_mem = 12'h200 * 4;
	localparam logic [11:0] a_scan = 12'h03C;
	localparam logic [11:0] a_gpo = 12'h040;
	localparam logic [11:0] a_bad = 12'h7F0;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic fast_osc_ck = 1'b0;
	logic sub_osc_ck = 1'b0;
	lcdpd_pins_t panel;
	lcdpd_analog_t analog;
	logic panel_power_on;
	logic sub_osc_enable;
	logic clr = 1'b0;
	logic [319:0] image;
	logic [7:0] com_seen;
	int multi;
	int errors = 0;
	int cmp_count = 0;
	int m_frame, m_osc, m_strong, m_panel;
	int m_mem[40];

	initial forever #5 aclk = ~aclk;
	// oscillators at half the bus clock, edges clear of the sampling edge
	initial begin
		#2.5;
		forever #10 fast_osc_ck = ~fast_osc_ck;
	end
	initial begin
		#2.5;
		forever #10 sub_osc_ck = ~sub_osc_ck;
	end

	lcdpd_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fast_osc_ck,
		.sub_osc_ck, .panel, .analog, .panel_power_on, .sub_osc_enable);
	lcdpd_glass glass (.aclk, .clr, .panel, .image, .com_seen, .multi);

	task automatic chk(input logic [63:0] s, input logic [63:0] e, input string m);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t %s: seen %0h exp %0h", $time, m, s, e);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		if (s_axi_bvalid !== 1'b1) chk(0, 1, "write answer missing");
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [33:0] v);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		if (s_axi_rvalid !== 1'b1) chk(0, 1, "read answer missing");
		v = {s_axi_rresp, s_axi_rdata};
		s_axi_rready <= 1'b0;
	endtask

	function automatic logic [33:0] mrd(input logic [11:0] a);
		case (a)
			a_frame: return {26'h0, 8'(m_frame)};
			a_osc: return {26'h0, 8'(m_osc)};
			a_strong: return {26'h0, 8'(m_strong)};
			a_panel: return 34'h0;
			default: ;
		endcase
		if (a >= a_mem && a < a_mem + 12'd160) return {26'h0, 8'(m_mem[(a - a_mem) >> 2])};
		return {2'b10, 32'h0};
	endfunction

	task automatic put(input logic [11:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		case (a)
			a_frame: m_frame = d & 8'h3F;
			a_osc: m_osc = d & 8'hE0;
			a_strong: m_strong = d & 8'h02;
			a_panel: m_panel = d;
			default: if (a >= a_mem && a < a_mem + 12'd160) m_mem[(a - a_mem) >> 2] = d;
		endcase
		chk(r, mrd(a) >> 32, "write response");
	endtask

	task automatic get(input logic [11:0] a);
		logic [33:0] v;
		rd(a, v);
		chk(v, mrd(a), "read");
	endtask

	task automatic mrst();
		m_frame = 8'h04;
		m_osc = 0;
		m_strong = 0;
		m_panel = 0;
	endtask

	task automatic pins();
		logic [8:0] e;
		repeat (2) @(posedge aclk);
		e = {m_strong[1], m_panel[4], m_frame[5:3], 3'(4 - m_panel[2:1]), m_panel[0]};
		chk(analog, e, "analog");
		chk(panel_power_on, !m_panel[7], "power");
		chk(sub_osc_enable, m_osc[6], "osc enable");
	endtask

	// counts oscillator edges between two phase steps of the commons
	task automatic tick(input int e, input bit f);
		int c;
		logic o, q;
		logic [7:0] p;
		c = -1;
		o = 1'b0;
		p = panel.com;
		for (int i = 0; i < 80000 && c < e + 8; i++) begin
			@(posedge aclk);
			if (panel.com !== p) begin
				if (c >= 0) break;
				c = 0;
				p = panel.com;
			end
			q = f ? fast_osc_ck : sub_osc_ck;
			if (q && !o && c >= 0) c++;
			o = q;
		end
		chk(c >= e - 3 && c <= e + 3, 1'b1, "frame rate");
	endtask

	task automatic clear_glass();
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
	endtask

	initial begin
		#1000000;
		chk(0, 1, "watchdog");
		complete_run();
	end

	initial begin
		logic [1:0] r;
		void'($urandom(32'h8ED2));
		mrst();
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		get(a_frame);
		get(a_osc);
		get(a_strong);
		get(a_panel);
		get(a_bad);
		pins();
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			put(a_frame, 8'($urandom));
			put(a_strong, 8'($urandom));
			put(a_panel, {1'b0, 4'($urandom), 2'(i), 1'($urandom)});
			get(a_frame);
			get(a_strong);
			get(a_panel);
			pins();
		end
		put(a_bad, 8'hFF);
		$display("register test done");
		for (int g = 0; g < 40; g++) put(a_mem + 12'(4 * g), 8'($urandom));
		put(a_osc, 8'h40);
		put(a_panel, 8'h80);
		pins();
		chk(panel, 0, "power off pins");
		repeat (100) @(posedge aclk);
		put(a_frame, 8'h04);
		put(a_panel, 8'h01);
		clear_glass();
		for (int n = 0; n < 4000 && com_seen !== 8'hFF; n++) begin
			get(a_mem + 12'(4 * ($urandom % 40)));
		end
		for (int g = 0; g < 40; g++) chk(image[g * 8 +: 8], m_mem[g], "image");
		chk(multi, 0, "one common at a time");
		$display("eighth duty scan done");
		put(a_panel, 8'h00);
		tick(512, 0);
		clear_glass();
		for (int k = 0; k < 2; k++) tick(512, 0);
		chk(com_seen, 8'h0F, "quarter duty commons");
		for (int s = 5; s < 8; s++) begin
			put(a_frame, 8'(s));
			tick(512, 0);
		end
		$display("quarter duty and crystal rates done");
		put(a_panel, 8'h41);
		pins();
		chk(panel.seg, 40'h0, "blank segments");
		tick(512, 0);
		wr(a_gpo, 8'h05, r);
		put(a_panel, 8'h48);
		pins();
		chk(panel.seg, 40'h5, "segment reuse");
		wr(a_scan, 8'hA0, r);
		put(a_panel, 8'h21);
		pins();
		chk(panel.com[7:4], 4'hA, "common reuse");
		$display("blank and pin reuse done");
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		mrst();
		get(a_mem + 12'd4);
		pins();
		put(a_frame, 8'h03);
		tick(16384, 1);
		$display("second reset and fast rate done");
		complete_run();
	end
endmodule // lcd_panel_driver_tb_top
